// [hw/dwi_top.sv]
// Purpose: digital front end of an 8-bit current-steering converter
// Assumes: data source meets setup/hold to clk; strap and power-down are
//          asynchronous pins and are synchronised here
// Notes: analog currents are represented by their steering codes
// How it works
// - capture whole word each rising edge
// - output follows capture by one cycle
// - strap low binary, strap high twos complement
// - twos complement flips the top bit
// - positive share equals code over 255
// - negative share equals 255 minus code
// - power-down high turns currents off
`timescale 1ns/100ps
module dwi_top
  import dwi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data word from the source
  input wire logic [7:0] input_data_word,
  // strap and power-down pins (tie power-down low if unused)
  input wire logic format_strap,
  input wire logic power_down,
  // steering codes to the current array
  output logic [7:0] positive_current_output,
  output logic [7:0] negative_current_output,
  output logic outputs_enabled
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when last two agree
  // a pin change reaches fmt_r or pd_r on the fourth edge after it and
  // the outputs one edge later; the strap is meant to be static, so
  // this delay only matters for power-down entry and exit
  logic [2:0] fmt_sync_r, fmt_sync_nxt;   // strap shift chain
  logic [2:0] pd_sync_r, pd_sync_nxt;     // power-down shift chain
  logic fmt_r, fmt_nxt;                   // filtered strap level
  logic pd_r, pd_nxt;                     // filtered power-down level

  // shift chains and agreement filter
  always_comb begin
    fmt_sync_nxt = {fmt_sync_r[1:0], format_strap};
    pd_sync_nxt = {pd_sync_r[1:0], power_down};
    fmt_nxt = fmt_r;
    pd_nxt = pd_r;
    // stage 0 is never looked at, only stages 1 and 2
    if (fmt_sync_r[1] == fmt_sync_r[2]) begin
      fmt_nxt = fmt_sync_r[2];
    end
    if (pd_sync_r[1] == pd_sync_r[2]) begin
      pd_nxt = pd_sync_r[2];
    end
  end

  // register sync state; reset assumes strap low and device awake
  always_ff @(posedge clk) begin
    if (rst) begin
      fmt_sync_r <= 3'h0;
      pd_sync_r <= 3'h0;
      fmt_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      fmt_sync_r <= fmt_sync_nxt;
      pd_sync_r <= pd_sync_nxt;
      fmt_r <= fmt_nxt;
      pd_r <= pd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input capture: the whole word is taken at every rising edge and
  // conversion only ever looks at this copy, so a word that changes
  // between edges never reaches the current array half updated
  logic [7:0] word_r, word_nxt; // captured input word

  // next captured word is the word standing at the pins
  always_comb begin
    word_nxt = input_data_word;
  end

  // capture stage; reset loads the zero code
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= DWI_CODE_RST;
    end else begin
      word_r <= word_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // code mapping on the captured word; the output register below adds
  // the one cycle between the capturing edge and the new currents
  dwi_fmt_e fmt_sel;   // strap as format enum
  logic [7:0] code;    // effective code of the captured word

  assign fmt_sel = dwi_fmt_e'(fmt_r);

  dwi_code_map dwi_code_map_inst (
    .word(word_r),
    .fmt(fmt_sel),
    .code(code)
  );

  ////////////////////////////////////////////////////////////////////////
  // output registers
  dwi_out_s out_r, out_nxt;  // registered steering pair

  // next output pair from the captured word; standby overrides below
  // standby zeroes both shares rather than freezing them, so a sleeping
  // array never sinks current on either output
  always_comb begin
    out_nxt.pos_code = code;
    out_nxt.neg_code = DWI_FULL_CODE - code;
    out_nxt.on = ~pd_r;
    if (pd_r) begin
      // currents off in standby: both shares zero
      out_nxt.pos_code = DWI_CODE_RST;
      out_nxt.neg_code = DWI_CODE_RST;
    end
  end

  // one register stage: fixed single-cycle latency, held between edges
  always_ff @(posedge clk) begin
    if (rst) begin
      out_r <= '{pos_code: DWI_CODE_RST, neg_code: DWI_CODE_RST, on: 1'b0};
    end else begin
      out_r <= out_nxt;
    end
  end

  assign positive_current_output = out_r.pos_code;
  assign negative_current_output = out_r.neg_code;
  assign outputs_enabled = out_r.on;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // timing seen by the checks below: a word standing before edge k is
  // in word_r after edge k and in the outputs after edge k+1, so a
  // property triggered at edge k+1 compares against the pins two
  // samples back and against the mapped code one sample back
  logic past_ok_r; // one cycle out of reset seen
  always_ff @(posedge clk) begin
    if (rst) begin
      past_ok_r <= 1'b0;
    end else begin
      past_ok_r <= 1'b1;
    end
  end

  out_latency_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && !pd_r |=> positive_current_output == $past(code))
    else $error("output does not follow word after one cycle");

  word_capture_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && !pd_r && !fmt_r |=>
      positive_current_output == $past(input_data_word, 2))
    else $error("binary word not captured whole");

  twos_flip_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && !pd_r && fmt_r |=>
      positive_current_output == ($past(input_data_word, 2) ^ 8'h80))
    else $error("top bit not flipped in twos complement");

  capture_reg_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r |-> word_r == $past(input_data_word))
    else $error("captured word differs from the pins");

  comp_sum_a: assert property (@(posedge clk) disable iff (rst)
    outputs_enabled |->
      8'(positive_current_output + negative_current_output) == 8'hFF)
    else $error("complementary shares do not sum to full code");

  neg_share_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && !pd_r |=> negative_current_output == 8'hFF - $past(code))
    else $error("negative share is not the complement of the code");

  pd_off_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && pd_r |=> !outputs_enabled && positive_current_output == 8'h00
      && negative_current_output == 8'h00)
    else $error("currents not off in power-down");

  enabled_on_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && !pd_r |=> outputs_enabled)
    else $error("currents off while awake");

  hold_out_a: assert property (@(posedge clk) disable iff (rst)
    past_ok_r && $stable(word_r) && $stable(fmt_r) && $stable(pd_r)
      |=> $stable(positive_current_output))
    else $error("output changed without a new word");

  pd_sync_a: assert property (@(posedge clk) disable iff (rst)
    pd_sync_r[2] && pd_sync_r[1] |=> pd_r)
    else $error("power-down not taken after agreement");

  pd_filter_a: assert property (@(posedge clk) disable iff (rst)
    pd_sync_r[2] != pd_sync_r[1] |=> pd_r == $past(pd_r))
    else $error("power-down level moved while stages disagree");

  fmt_sync_a: assert property (@(posedge clk) disable iff (rst)
    fmt_sync_r[2] == fmt_sync_r[1] |=> fmt_r == $past(fmt_sync_r[2]))
    else $error("strap not taken after agreement");

  fmt_filter_a: assert property (@(posedge clk) disable iff (rst)
    fmt_sync_r[2] != fmt_sync_r[1] |=> fmt_r == $past(fmt_r))
    else $error("strap level moved while stages disagree");

  // main scenarios: full positive code in binary, full negative code in twos complement, back-to-back boundary
  // words, standby entry and exit
  cov_binary_c: cover property (@(posedge clk) !fmt_r && !pd_r ##1
    positive_current_output == 8'hFF);
  cov_twos_c: cover property (@(posedge clk) fmt_r && !pd_r ##1
    negative_current_output == 8'hFF);
  cov_sleep_c: cover property (@(posedge clk) outputs_enabled ##1
    !outputs_enabled);
  cov_wake_c: cover property (@(posedge clk) !outputs_enabled ##1
    outputs_enabled);
  cov_step_c: cover property (@(posedge clk)
    positive_current_output == 8'h00 ##1 positive_current_output == 8'hFF);
endmodule : dwi_top

// [hw/dwi_pkg.sv]
// Purpose: shared constants and types for the dac input word interface
// Assumes: 8-bit input word, single clock, synchronous active-high reset
// Notes: codes are unsigned steering codes toward the two current outputs
package dwi_pkg;
  localparam int DWI_WORD_W = 8;            // width of the input data word
  localparam int DWI_MSB = DWI_WORD_W - 1;  // position of the sign bit
  localparam logic [7:0] DWI_CODE_RST = 8'h00; // code after reset
  localparam logic [7:0] DWI_FULL_CODE = 8'hFF; // largest effective code
  localparam int DWI_LATENCY = 1;           // cycles from capture to output

  // input format selected by the strap
  typedef enum logic [0:0] {
    DWI_FMT_BINARY = 1'b0,
    DWI_FMT_TWOS = 1'b1
  } dwi_fmt_e;

  // pair of complementary steering codes
  typedef struct packed {
    logic [7:0] pos_code;   // share steered to the positive output
    logic [7:0] neg_code;   // share steered to the negative output
    logic on;               // current sources enabled
  } dwi_out_s;
endpackage : dwi_pkg

// [hw/dwi_code_map.sv]
// Purpose: format mapping from captured word to effective code
// Assumes: purely combinational, same clock domain as caller
// Notes: twos complement is handled by flipping the top bit only
`timescale 1ns/100ps
module dwi_code_map
  import dwi_pkg::*;
(
  // captured word and format
  input wire logic [7:0] word,
  input wire dwi_fmt_e fmt,
  // effective code
  output logic [7:0] code
);
  // top bit flip maps signed range onto the binary scale
  always_comb begin
    code = word;
    if (fmt == DWI_FMT_TWOS) begin
      code[DWI_MSB] = ~word[DWI_MSB];
    end
  end
endmodule : dwi_code_map

// [testbench/dwi_source.sv]
// Purpose: data source model feeding words into the converter front end
// Assumes: bench calls send just after a rising clock edge
// Notes: holds the last word on the bus until told otherwise
`timescale 1ns/100ps
module dwi_source;
  // word bus toward the converter
  logic [7:0] data_word = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // one word per call; the bench paces calls to one per clock at most,
  // and one word per 10 ns clock is only allowed on the upper digital
  // supply range, which this model takes as given
  task automatic send(input logic [7:0] w);
    data_word = w;
  endtask : send
endmodule : dwi_source

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the converter input word front end
// Assumes: pins settle within five clocks after a change
// Notes: a word shows at the outputs two edges after it is driven
`timescale 1ns/100ps
module tb_top;
  import dwi_pkg::*;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic pd = 1'b0;
  logic [7:0] pos;
  logic [7:0] neg;
  logic en;
  int num_errors = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  dwi_source dwi_source_inst ();
  dwi_top dwi_top_inst (.clk(clk), .rst(rst),
    .input_data_word(dwi_source_inst.data_word), .format_strap(strap),
    .power_down(pd), .positive_current_output(pos),
    .negative_current_output(neg), .outputs_enabled(en));
  ////////////////////////////////////////////////////////////////////////
  task automatic expect_out(input logic [7:0] p, input logic e);
    `CHK("pos", p, pos)
    `CHK("neg", e ? (8'hFF - p) : 8'h00, neg)
    `CHK("en", e, en)
  endtask : expect_out
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask : settle
  // back-to-back words, boundary codes; flip marks twos complement;
  // each edge shows the word sent one edge before the last one
  task automatic run_words(input logic flip);
    logic [7:0] w [5] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h01};
    for (int i = 0; i <= 5; i++) begin
      if (i < 5) begin
        dwi_source_inst.send(w[i]);
      end
      @(posedge clk);
      #1;
      if (i > 0) begin
        expect_out(w[i-1] ^ {flip, 7'h00}, 1'b1);
      end
    end
    $display("test words flip=%0d done", flip);
  endtask : run_words
  // reset clears all; first edge after release converts the reset word
  task automatic test_reset();
    repeat (20) @(posedge clk);
    #1;
    expect_out(8'h00, 1'b0);
    rst = 1'b0;
    @(posedge clk);
    #1;
    expect_out(8'h00, 1'b1);
    $display("test reset done");
  endtask : test_reset
  // standby turns both shares off; after waking a new word waits its turn
  task automatic test_power_down();
    strap = 1'b0;
    pd = 1'b1;
    settle();
    expect_out(8'h00, 1'b0);
    pd = 1'b0;
    settle();
    dwi_source_inst.send(8'h5A);
    repeat (DWI_LATENCY + 1) @(posedge clk);
    #1;
    expect_out(8'h5A, 1'b1);
    dwi_source_inst.send(8'hA5);
    @(posedge clk);
    #1;
    expect_out(8'h5A, 1'b1);
    @(posedge clk);
    #1;
    expect_out(8'hA5, 1'b1);
    $display("test power down done");
  endtask : test_power_down
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    test_reset();
    run_words(1'b0);
    strap = 1'b1;
    settle();
    run_words(1'b1);
    test_power_down();
    end_of_test();
  end
  // watchdog well beyond the roughly 52 cycles the tests need
  initial begin
    #5000;
    num_errors++;
    end_of_test();
  end
endmodule : tb_top
